/* File: inc/ppwa_pkg.sv */
/*
 * Constants, field layout and carrier types of the parallel port
 * write-address and chip-select holding block.
 * Assumes a 32-bit Avalon-MM register bus with byte addressing.
 */
package ppwa_pkg;

    // Bus geometry
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned BE_W      = DATA_W / 8;
    localparam int unsigned MIN_ADR_W = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_WRITE_TARGET_ADDRESS = 4'h0;
    localparam logic [3:0] OFS_CTRL  = 4'h4;
    localparam logic [3:0] OFS_STAT  = 4'h8;

    // Write address register fields
    localparam int unsigned CHIP_SELECT_TWO_ALT_BIT  = 23;
    localparam int unsigned CHIP_SELECT_ONE_ALT_BIT  = 22;
    localparam int unsigned EXT_MSB   = 21;
    localparam int unsigned EXT_LSB   = 16;
    localparam int unsigned CS2_BIT   = 15;
    localparam int unsigned CS1_BIT   = 14;
    localparam int unsigned LOW_MSB   = 13;
    localparam int unsigned TADDR_W   = 24;

    // Control register fields
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_MODE_MSB = 1;
    localparam int unsigned CTRL_EXT_BIT  = 2;
    localparam int unsigned CTRL_DUAL_BIT = 17;

    // Implemented bits and reset values
    localparam logic [31:0] WRITE_TARGET_ADDRESS_MASK = 32'h00FFFFFF;
    localparam logic [31:0] CTRL_MASK  = 32'h00020007;
    localparam logic [31:0] WRITE_TARGET_ADDRESS_RST  = 32'h00000000;
    localparam logic [31:0] CTRL_RST   = 32'h00000000;

    // Chip-select mode field encodings
    typedef enum logic [1:0] {
        CSM_ADDR = 2'b00,
        CSM_ONE  = 2'b01,
        CSM_TWO  = 2'b10,
        CSM_RSVD = 2'b11
    } ppwa_csmode_t;

    // Bus slave states
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } ppwa_bus_t;

    // Control bits that steer the decoder
    typedef struct packed {
        ppwa_csmode_t mode;
        logic         extAddr;
        logic         dual_buffer_enable;
    } ppwa_ctrl_t;

    // Lines presented toward the external peripheral
    typedef struct packed {
        logic [TADDR_W-1:0] targetAddr;
        logic               csTwo;
        logic               csOne;
        logic               csTwoAlt;
        logic               csOneAlt;
        logic               cycleValid;
    } ppwa_pins_t;

    localparam int unsigned PINS_W = $bits(ppwa_pins_t);

endpackage : ppwa_pkg

/* File: core/ppwa_decode.sv */
/*
 * Combinational decoder: splits the held write address word into
 * target address bits and chip-select lines by the mode field.
 * Assumes the caller registers the result before it leaves the chip.
 */
`timescale 1ns/1ns
module ppwa_decode (
    // Held register contents and the write cycle flag
    input  wire logic [31:0]          write_target_address,
    input  wire ppwa_pkg::ppwa_ctrl_t ctrl,
    input  wire logic                 writeCycle,
    // Decoded lines
    output ppwa_pkg::ppwa_pins_t      pins
);
    import ppwa_pkg::*;

    logic extOn;

    // Upper address bits need both extended and dual buffering
    assign extOn = ctrl.extAddr & ctrl.dual_buffer_enable;

    // Mode decode; everything stays low while dual buffering is off
    always_comb begin
        pins = '0;
        if (ctrl.dual_buffer_enable) begin
            pins.targetAddr[LOW_MSB:0] = write_target_address[LOW_MSB:0];
            pins.cycleValid = writeCycle;
            if (extOn) begin
                pins.targetAddr[EXT_MSB:EXT_LSB] =
                    write_target_address[EXT_MSB:EXT_LSB];
            end
            unique case (ctrl.mode)
                CSM_ADDR: begin
                    pins.targetAddr[CS2_BIT] = write_target_address[CS2_BIT];
                    pins.targetAddr[CS1_BIT] = write_target_address[CS1_BIT];
                    if (extOn) begin
                        pins.targetAddr[CHIP_SELECT_TWO_ALT_BIT] = write_target_address[CHIP_SELECT_TWO_ALT_BIT];
                        pins.targetAddr[CHIP_SELECT_ONE_ALT_BIT] = write_target_address[CHIP_SELECT_ONE_ALT_BIT];
                    end
                end
                CSM_ONE: begin
                    pins.csTwoAlt = write_target_address[CHIP_SELECT_TWO_ALT_BIT];
                    pins.csTwo    = write_target_address[CS2_BIT];
                    pins.targetAddr[CS1_BIT] = write_target_address[CS1_BIT];
                end
                CSM_TWO: begin
                    pins.csTwoAlt = write_target_address[CHIP_SELECT_TWO_ALT_BIT];
                    pins.csOneAlt = write_target_address[CHIP_SELECT_ONE_ALT_BIT];
                    pins.csTwo    = write_target_address[CS2_BIT];
                    pins.csOne    = write_target_address[CS1_BIT];
                end
                CSM_RSVD: begin
                    pins.csTwo = 1'b0; // Reserved: no select, no bits
                end
            endcase
        end
    end

endmodule : ppwa_decode

/* File: core/ppwa_top.sv */
/*
 * Parallel port write-address and chip-select holding register with
 * its control bits, reached over an Avalon-MM slave with waitrequest.
 * Assumes one clock, a master that holds each request until it sees
 * waitrequest low, and a strobe sequencer on the same clock that
 * raises writeCycle during a port write cycle.
 */
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
// Contract
// - Mode 10: bits 23,22 are selects 2a,1a
// - Mode 01: bit 23 is select 2a
// - Mode 00, ext and dual: bits 23,22 address
// - Bits 21:16 address only with ext and dual
// - Mode 10: bits 15,14 are selects 2,1
// - Mode 01: bit 15 is select 2
// - Mode 00: bit 15 is address bit
// - Mode 00 or 01: bit 14 address
// - Register acts only while dual buffering on
// - Bits 31:24 read zero; reset clears all
`timescale 1ns/1ns
module ppwa_top #(
    parameter int unsigned ADR_W = 4
) (
    // Clock and reset
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    // Avalon-MM register slave
    input  wire logic [ADR_W-1:0]              avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [ppwa_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [ppwa_pkg::BE_W-1:0]     avs_byteenable,
    output logic      [ppwa_pkg::DATA_W-1:0]   avs_readdata,
    output logic                               avs_waitrequest,
    // Strobe sequencer side
    input  wire logic                          writeCycle,
    // Lines toward the external peripheral
    output ppwa_pkg::ppwa_pins_t               portPins
);
    import ppwa_pkg::*;

    // Refuse an address bus too narrow for the map
    if (ADR_W < MIN_ADR_W) begin : g_adr_check
        $error("ppwa_top: ADR_W must be at least 4");
    end

    // Byte-enable merge, restricted to implemented bits
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  be,
        input logic [31:0] mask
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res & mask;
    endfunction : mergeBytes

    // Offset match on the low address bits, all higher address bits zero
    function automatic logic hitOfs(
        input logic [ADR_W-1:0] adr,
        input logic [3:0]       ofs
    );
        return (adr[3:0] == ofs) && (adr[ADR_W-1:2] ==
            {{(ADR_W-2){1'b0}}} + ofs[3:2]);
    endfunction : hitOfs

    ppwa_bus_t            busR;
    ppwa_bus_t            busNxt;
    logic [31:0]          wAddrR;
    logic [31:0]          ctrlR;
    logic [31:0]          rdDataR;
    logic [31:0]          rdDataNxt;
    ppwa_ctrl_t           ctrlBits;
    ppwa_pins_t           pinsNxt;
    ppwa_pins_t           pinsR;
    logic                 request;
    logic                 writeTake;
    logic                 hitWaddr;
    logic                 hitCtrl;
    logic                 hitStat;

    // Request decode
    assign request   = avs_read | avs_write;
    assign hitWaddr  = hitOfs(avs_address, OFS_WRITE_TARGET_ADDRESS);
    assign hitCtrl   = hitOfs(avs_address, OFS_CTRL);
    assign hitStat   = hitOfs(avs_address, OFS_STAT);
    assign writeTake = avs_write & (busR == BUS_ACK);

    // One wait state on every access, then the answer
    assign avs_waitrequest = request & (busR == BUS_IDLE);
    assign avs_readdata    = rdDataR;

    // Bus slave state sequence
    always_comb begin
        busNxt = busR;
        unique case (busR)
            BUS_IDLE: begin
                if (request) begin
                    busNxt = BUS_ACK;
                end
            end
            BUS_ACK: begin
                busNxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busR <= BUS_IDLE;
        end else begin
            busR <= busNxt;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdDataNxt = '0;
        if (hitWaddr) begin
            rdDataNxt = wAddrR & WRITE_TARGET_ADDRESS_MASK;
        end else if (hitCtrl) begin
            rdDataNxt = ctrlR & CTRL_MASK;
        end else if (hitStat) begin
            rdDataNxt = {{(DATA_W-PINS_W){1'b0}}, pinsR};
        end
    end

    // Read data captured in the wait cycle, stands in the answer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdDataR <= '0;
        end else if (avs_read && busR == BUS_IDLE) begin
            rdDataR <= rdDataNxt;
        end
    end

    // Write address register, cleared at reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wAddrR <= WRITE_TARGET_ADDRESS_RST;
        end else if (writeTake && hitWaddr) begin
            wAddrR <= mergeBytes(wAddrR, avs_writedata,
                                 avs_byteenable, WRITE_TARGET_ADDRESS_MASK);
        end
    end

    // Control register holding mode, extended and dual bits
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlR <= CTRL_RST;
        end else if (writeTake && hitCtrl) begin
            ctrlR <= mergeBytes(ctrlR, avs_writedata,
                                avs_byteenable, CTRL_MASK);
        end
    end

    // Control fields for the decoder
    assign ctrlBits.mode    =
        ppwa_csmode_t'(ctrlR[CTRL_MODE_MSB:CTRL_MODE_LSB]);
    assign ctrlBits.extAddr = ctrlR[CTRL_EXT_BIT];
    assign ctrlBits.dual_buffer_enable = ctrlR[CTRL_DUAL_BIT];

    // Address and select decode
    ppwa_decode u_decode (
        .write_target_address      (wAddrR),
        .ctrl       (ctrlBits),
        .writeCycle (writeCycle),
        .pins       (pinsNxt)
    );

    // Registered lines toward the peripheral
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinsR <= '0;
        end else begin
            pinsR <= pinsNxt;
        end
    end

    assign portPins = pinsR;

    // Mode 10 drives both alternate selects from bits 23 and 22
    AST_ALT_SELECTS: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.mode == CSM_TWO)
        |=> (pinsR.csTwoAlt == $past(wAddrR[CHIP_SELECT_TWO_ALT_BIT]))
            && (pinsR.csOneAlt == $past(wAddrR[CHIP_SELECT_ONE_ALT_BIT]))
            && (pinsR.targetAddr[CHIP_SELECT_TWO_ALT_BIT:CHIP_SELECT_ONE_ALT_BIT] == 2'h0)
    ) else $error("mode 10 alternate selects wrong");

    // Mode 01 drives select 2a only, bit 22 unused
    AST_ONE_ALT: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.mode == CSM_ONE)
        |=> (pinsR.csTwoAlt == $past(wAddrR[CHIP_SELECT_TWO_ALT_BIT]))
            && !pinsR.csOneAlt
    ) else $error("mode 01 select 2a wrong");

    // Mode 00 with extended addressing gives address bits 23:22
    AST_HIGH_ADDR: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.extAddr
            && ctrlBits.mode == CSM_ADDR)
        |=> (pinsR.targetAddr[CHIP_SELECT_TWO_ALT_BIT:CHIP_SELECT_ONE_ALT_BIT]
                == $past(wAddrR[CHIP_SELECT_TWO_ALT_BIT:CHIP_SELECT_ONE_ALT_BIT]))
            && !pinsR.csTwoAlt && !pinsR.csOneAlt
    ) else $error("mode 00 address bits 23:22 wrong");

    // Bits 21:16 follow only with both enables, else held low
    AST_EXT_ADDR: assert property (
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> (pinsR.targetAddr[EXT_MSB:EXT_LSB] ==
            (($past(ctrlBits.extAddr) && $past(ctrlBits.dual_buffer_enable))
                ? $past(wAddrR[EXT_MSB:EXT_LSB]) : 6'h00))
    ) else $error("extended address bits wrong");

    // Mode 10 drives selects 2 and 1 from bits 15 and 14
    AST_MAIN_SELECTS: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.mode == CSM_TWO)
        |=> (pinsR.csTwo == $past(wAddrR[CS2_BIT]))
            && (pinsR.csOne == $past(wAddrR[CS1_BIT]))
            && (pinsR.targetAddr[CS2_BIT:CS1_BIT] == 2'h0)
    ) else $error("mode 10 selects wrong");

    // Mode 01 drives select 2 from bit 15
    AST_ONE_SELECT: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.mode == CSM_ONE)
        |=> (pinsR.csTwo == $past(wAddrR[CS2_BIT]))
            && !pinsR.csOne && !pinsR.targetAddr[CS2_BIT]
    ) else $error("mode 01 select 2 wrong");

    // Mode 00 presents bit 15 as address, no select
    AST_BIT15_ADDR: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && ctrlBits.mode == CSM_ADDR)
        |=> (pinsR.targetAddr[CS2_BIT] == $past(wAddrR[CS2_BIT]))
            && !pinsR.csTwo
    ) else $error("mode 00 bit 15 wrong");

    // Modes 00 and 01 present bit 14 as address
    AST_BIT14_ADDR: assert property (
        @(posedge ref_clk) disable iff (rst)
        (ctrlBits.dual_buffer_enable && (ctrlBits.mode == CSM_ADDR
            || ctrlBits.mode == CSM_ONE))
        |=> (pinsR.targetAddr[CS1_BIT] == $past(wAddrR[CS1_BIT]))
            && !pinsR.csOne
    ) else $error("bit 14 address wrong");

    // Dual buffering off leaves every line low
    AST_DUAL_GATE: assert property (
        @(posedge ref_clk) disable iff (rst)
        !ctrlBits.dual_buffer_enable |=> (pinsR == '0)
    ) else $error("lines active without dual buffering");

    // Upper byte of the write address reads zero in the answer
    AST_UPPER_ZERO: assert property (
        @(posedge ref_clk) disable iff (rst)
        (avs_read && !avs_waitrequest && hitWaddr)
        |-> (avs_readdata[31:24] == 8'h00)
    ) else $error("upper byte read not zero");

    // Registers read zero one edge into any reset
    AST_RESET_CLEAR: assert property (
        @(posedge ref_clk)
        rst |=> (wAddrR == WRITE_TARGET_ADDRESS_RST) && (ctrlR == CTRL_RST)
    ) else $error("register not cleared by reset");

    // Low bits and the write cycle flag follow in every mode while dual buffering is on
    AST_LOW_ADDR: assert property (
        @(posedge ref_clk) disable iff (rst)
        ctrlBits.dual_buffer_enable |=>
            (pinsR.targetAddr[LOW_MSB:0] == $past(wAddrR[LOW_MSB:0]))
            && (pinsR.cycleValid == $past(writeCycle))
    ) else $error("low address bits wrong");

    // Every newly raised request answered after exactly one wait state
    AST_BUS_ANSWER: assert property (
        @(posedge ref_clk) disable iff (rst)
        ($rose(request) && busR == BUS_IDLE)
        |-> avs_waitrequest ##1 !avs_waitrequest
    ) else $error("bus answer not after one wait state");

endmodule : ppwa_top

/* File: verification/ppwa_periph_model.sv */
/*
 * Far-side peripheral model: latches the port lines on each flagged
 * write cycle so the bench can see what the peripheral received.
 * Assumes the port lines are registered on ref_clk.
 */
`timescale 1ns/1ns
module ppwa_periph_model (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Lines from the port
    input  wire ppwa_pkg::ppwa_pins_t pins,
    // Captured view
    output ppwa_pkg::ppwa_pins_t      seenPins
);
    import ppwa_pkg::*;

    // Capture only while a write cycle is flagged
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            seenPins <= '0;
        end else if (pins.cycleValid) begin
            seenPins <= pins;
        end
    end
endmodule : ppwa_periph_model

/* File: verification/ppwa_top_bench.sv */
/*
 * Self-checking bench for the write-address holding block: register
 * access, mode decode with random and corner words, reset clearing.
 * Assumes a one-wait-state Avalon slave and the package offsets.
 */
`timescale 1ns/1ns
module ppwa_top_bench;
    import ppwa_pkg::*;

    logic             ref_clk;
    logic             rst;
    logic [3:0]       avs_address;
    logic             avs_read;
    logic             avs_write;
    logic [31:0]      avs_writedata;
    logic [3:0]       avs_byteenable;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             writeCycle;
    ppwa_pins_t       portPins;
    ppwa_pins_t       seenPins;
    int               miscompares;
    int               n_checks;
    logic [31:0]      rd;

    ppwa_top ppwa_top_i (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .writeCycle      (writeCycle),
        .portPins        (portPins)
    );

    ppwa_periph_model ppwa_periph_model_i (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .pins     (portPins),
        .seenPins (seenPins)
    );

    // Clock, 4 ns period
    always #2 ref_clk = ~ref_clk;

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Avalon write, held until waitrequest sampled low
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_wr

    // Avalon read, data taken at the same edge
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_byteenable <= 4'hF;
        avs_read       <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_rd

    // Expected port lines from word and control bits
    function automatic ppwa_pins_t exp_pins(input logic [31:0] w,
        input logic [1:0] m, input logic ext, input logic dual,
        input logic wc);
        ppwa_pins_t p;
        p = '0;
        if (dual) begin
            p.cycleValid       = wc;
            p.targetAddr[13:0] = w[13:0];
            if (ext) p.targetAddr[21:16] = w[21:16];
            case (m)
                2'h0: begin
                    p.targetAddr[15:14] = w[15:14];
                    if (ext) p.targetAddr[23:22] = w[23:22];
                end
                2'h1: begin
                    p.csTwo          = w[15];
                    p.targetAddr[14] = w[14];
                    p.csTwoAlt       = w[23];
                end
                2'h2: begin
                    p.csTwo    = w[15];
                    p.csOne    = w[14];
                    p.csTwoAlt = w[23];
                    p.csOneAlt = w[22];
                end
                default: ;
            endcase
        end
        return p;
    endfunction : exp_pins

    // One decode case: program, settle, compare pins, status, model
    task automatic run_case(input logic [31:0] w, input logic [1:0] m,
                            input logic ext, input logic dual,
                            input logic wc);
        ppwa_pins_t e;
        @(posedge ref_clk);
        writeCycle <= wc;
        bus_wr(OFS_CTRL, {14'h0, dual, 14'h0, ext, m}, 4'hF);
        bus_wr(OFS_WRITE_TARGET_ADDRESS, w, 4'hF);
        repeat (2) @(posedge ref_clk);
        e = exp_pins(w, m, ext, dual, wc);
        chk("portPins", {3'h0, e}, {3'h0, portPins});
        chk("valid", 32'(e.cycleValid), 32'(portPins.cycleValid));
        bus_rd(OFS_STAT, rd);
        chk("status", {3'h0, e}, rd);
        if (wc && dual) chk("model", {3'h0, e}, {3'h0, seenPins});
    endtask : run_case

    // Verdict, single exit point
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // Watchdog on total run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end

    // Main sequence
    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        writeCycle = 1'b0;
        miscompares = 0;
        n_checks = 0;
        void'($urandom(9348));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values and unimplemented bits
        bus_rd(OFS_WRITE_TARGET_ADDRESS, rd);
        chk("write_target_address reset", 32'h0, rd);
        bus_rd(OFS_CTRL, rd);
        chk("ctrl reset", CTRL_RST, rd);
        chk("pins reset", 32'h0, {3'h0, portPins});
        bus_wr(OFS_WRITE_TARGET_ADDRESS, 32'hFFFFFFFF, 4'hF);
        bus_rd(OFS_WRITE_TARGET_ADDRESS, rd);
        chk("write_target_address upper", 32'h00FFFFFF, rd);
        bus_wr(OFS_WRITE_TARGET_ADDRESS, 32'h0, 4'hF);
        bus_wr(OFS_WRITE_TARGET_ADDRESS, 32'hAAAAAAAA, 4'h2);
        bus_rd(OFS_WRITE_TARGET_ADDRESS, rd);
        chk("write_target_address lane", 32'h0000AA00, rd);
        bus_wr(OFS_CTRL, 32'hFFFFFFFF, 4'hF);
        bus_rd(OFS_CTRL, rd);
        chk("ctrl mask", CTRL_MASK, rd);
        bus_wr(4'hC, 32'h12345678, 4'hF);
        bus_rd(4'hC, rd);
        chk("unmapped", 32'h0, rd);
        $display("test registers done");
        // Every mode, enable pair, all-ones then random word
        for (int i = 0; i < 32; i++) begin
            run_case(i[4] ? $urandom() : 32'hFFFFFFFF, i[1:0], i[2],
                     i[3], 1'b1);
        end
        $display("test mode table done");
        // Random words, modes and write-cycle flag
        for (int i = 0; i < 40; i++) begin
            run_case($urandom(), 2'($urandom()), 1'($urandom()),
                     1'($urandom()), 1'($urandom()));
        end
        $display("test random done");
        // Reset in mid-run clears the write address and the port lines
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        bus_rd(OFS_WRITE_TARGET_ADDRESS, rd);
        chk("write_target_address rerst", 32'h0, rd);
        chk("pins rerst", 32'h0, {3'h0, portPins});
        $display("test second reset done");
        stop_test();
    end
endmodule : ppwa_top_bench
